// ==== burst_read_pkg.sv ====
// Shared constants for the master burst read data-phase block.
// Assumes one clock domain and a plain register port on the host side.
`default_nettype none

package burst_read_pkg;

  // Register port
  localparam int           REG_AW        = 4;
  localparam logic [3:0]   REG_CTRL      = 4'h0;
  localparam logic [3:0]   REG_STATUS    = 4'h4;
  localparam logic [3:0]   REG_COUNT     = 4'h8;
  localparam int           CTRL_EN_BIT   = 0;
  localparam logic         CTRL_EN_RST   = 1'b1;

  // Transaction status layout
  localparam int           TSR_W         = 10;
  localparam int           TSR_DATA_BIT  = 3;
  localparam int           TSR_XFER_BIT  = 8;
  localparam int           TSR_W64_BIT   = 9;

  // Data path
  localparam int           DATA_W        = 64;
  localparam int           FIFO_DEPTH    = 16;
  localparam int           COUNT_W       = 16;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_DATA  = 3'b010,
    ST_DRAIN = 3'b100
  } phase_state_t;

endpackage : burst_read_pkg

`default_nettype wire

// ==== word_fifo_if.sv ====
// Valid/ready carrier between the read data path and its word FIFO.
// Assumes both ends run on the same clock.
`default_nettype none

interface word_fifo_if #(
  parameter int WIDTH = 64
);
  logic             in_valid;
  logic             in_ready;
  logic [WIDTH-1:0] in_data;
  logic             out_valid;
  logic             out_ready;
  logic [WIDTH-1:0] out_data;
  logic             room2;

  modport fill  (output in_valid, in_data, out_ready,
                 input  in_ready, out_valid, out_data, room2);
  modport store (input  in_valid, in_data, out_ready,
                 output in_ready, out_valid, out_data, room2);
endinterface : word_fifo_if

`default_nettype wire

// ==== word_fifo.sv ====
// Flip-flop word FIFO with valid/ready on both sides.
// Assumes the filler only pushes when in_ready is high.
`default_nettype none

module word_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic  clk,
  input  wire logic  sys_rst,
  // Storage side
  word_fifo_if.store fifo
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;

  wire push = fifo.in_valid && fifo.in_ready;
  wire pop  = fifo.out_valid && fifo.out_ready;

  function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
    next_ptr = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction : next_ptr

  assign fifo.in_ready  = (count_r != (AW+1)'(DEPTH));
  assign fifo.out_valid = (count_r != '0);
  assign fifo.out_data  = mem_r[rd_ptr_r];
  // Two free slots: one word may already be in flight on the bus
  assign fifo.room2     = (count_r < (AW+1)'(DEPTH - 1));

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= fifo.in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) wr_ptr_r <= next_ptr(wr_ptr_r);
      if (pop)  rd_ptr_r <= next_ptr(rd_ptr_r);
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule : word_fifo

`default_nettype wire

// ==== burst_read_data.sv ====
// Data-phase engine of a bus master burst memory read, plus register port.
// Assumes the address phase and termination logic sit outside; start_data
// pulses in the address-phase cycle and bus inputs are synchronous to clk.
//
// Function
// - First data phase drives initiator-ready regardless of local ready.
// - Later data phases wait for local ready before initiator-ready.
// - Entering data phases sets status bit 3.
// - Target 64-bit acknowledge sets status bit 9.
// - Phase completes on edge after initiator-ready and target-ready both low.
// - Local acknowledge follows registered read data by one cycle.
// - Transfer strobe needs acknowledge now and local ready last cycle.
// - Strobe with dword acknowledges marks read data valid.
// - Last request during a completing phase allows at most one more.
// - Status bit 8 follows each completed data transfer.
// - End of data phases clears bit 3, acknowledge and strobe; here only once the last word has left the FIFO.
//
// Local design decisions: the strobed register port and the register addresses.
`default_nettype none

module burst_read_data
  import burst_read_pkg::*;
#(
  parameter int DEPTH = burst_read_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                               clk,
  input  wire logic                               sys_rst,
  // Register port
  input  wire logic [burst_read_pkg::REG_AW-1:0]  reg_addr,
  input  wire logic [31:0]                        reg_wdata,
  input  wire logic                               reg_wr,
  input  wire logic                               reg_rd,
  output logic      [31:0]                        reg_rdata,
  // Link to address-phase and termination logic
  input  wire logic                               start_data,
  input  wire logic                               abort_data,
  // Shared bus, initiator side
  output logic                                    irdy_n_o,
  output logic                                    irdy_n_oe,
  input  wire logic                               devsel_n,
  input  wire logic                               ack64_n,
  input  wire logic                               trdy_n,
  input  wire logic [burst_read_pkg::DATA_W-1:0]  ad_in,
  // Local master side
  input  wire logic                               local_master_ready_n,
  input  wire logic                               local_last_transfer_request_n,
  output logic                                    local_master_acknowledge_n,
  output logic                                    local_master_transfer_strobe_n,
  output logic                                    low_dword_ack_n,
  output logic                                    high_dword_ack_n,
  output logic      [burst_read_pkg::DATA_W-1:0]  local_read_data,
  output logic      [burst_read_pkg::TSR_W-1:0]   master_transaction_status
);

  import burst_read_pkg::*;

  word_fifo_if #(.WIDTH(DATA_W)) wf ();

  word_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk     (clk),
    .sys_rst (sys_rst),
    .fifo    (wf.store)
  );

  phase_state_t           state_r;
  phase_state_t           state_nxt;
  logic                   enable_r;
  logic                   irdy_r;
  logic                   irdy_nxt;
  logic                   irdy_n_r;
  logic                   irdy_oe_r;
  logic                   first_r;
  logic                   armed_r;
  logic                   last_seen_r;
  logic                   wide_r;
  logic                   tsr_data_r;
  logic                   tsr_xfer_r;
  logic                   tsr_w64_r;
  logic                   ack_n_r;
  logic                   dxfr_n_r;
  logic                   ldat_n_r;
  logic                   hdat_n_r;
  logic [DATA_W-1:0]      dato_r;
  logic [COUNT_W-1:0]     count_r;
  logic [31:0]            rdata_r;

  wire in_data_mode = (state_r == ST_DATA);
  wire local_rdy    = !local_master_ready_n;
  wire last_req     = !local_last_transfer_request_n;

  // both ready low in the cycle just ending
  wire phase_done   = in_data_mode && irdy_r && !trdy_n;

  // at most the current and one following phase
  wire final_phase  = phase_done && armed_r;
  wire arm_last     = phase_done && (last_req || last_seen_r);

  wire go_data      = (state_r == ST_IDLE) && start_data && enable_r;
  wire bus_end      = final_phase || (in_data_mode && abort_data);

  // Words move to the local side only while it signals ready
  wire pop_word     = wf.out_valid && local_rdy;
  wire drained      = !wf.out_valid && (state_r == ST_DRAIN);

  assign wf.in_valid  = phase_done;
  assign wf.in_data   = ad_in;
  assign wf.out_ready = local_rdy;

  // later phases need local ready and FIFO room
  wire next_ok = local_rdy && wf.room2;

  always_comb begin
    irdy_nxt = 1'b0;
    if (go_data) begin
      // first phase asserts regardless of local ready
      irdy_nxt = 1'b1;
    end else if (in_data_mode && !bus_end) begin
      if (phase_done || !irdy_r) begin
        irdy_nxt = next_ok;
      end else begin
        // A started phase holds initiator-ready until it completes;
        // the first phase never waits on local ready
        irdy_nxt = irdy_r || first_r;
      end
    end
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (go_data) state_nxt = ST_DATA;
      end
      ST_DATA: begin
        if (bus_end) state_nxt = ST_DRAIN;
      end
      ST_DRAIN: begin
        if (drained) state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r   <= ST_IDLE;
      irdy_r    <= 1'b0;
      irdy_n_r  <= 1'b1;
      irdy_oe_r <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      irdy_r    <= irdy_nxt;
      irdy_n_r  <= !irdy_nxt;
      irdy_oe_r <= (state_nxt == ST_DATA);
    end
  end

  // The pin has its own active-low flop so no inverter follows it
  assign irdy_n_o  = irdy_n_r;
  assign irdy_n_oe = irdy_oe_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      first_r     <= 1'b0;
      armed_r     <= 1'b0;
      last_seen_r <= 1'b0;
    end else if (go_data) begin
      first_r     <= 1'b1;
      armed_r     <= 1'b0;
      last_seen_r <= 1'b0;
    end else begin
      if (phase_done) first_r <= 1'b0;
      if (arm_last) armed_r <= 1'b1;
      if (in_data_mode && last_req) last_seen_r <= 1'b1;
    end
  end

  // Status bits
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tsr_data_r <= 1'b0;
      tsr_xfer_r <= 1'b0;
    end else begin
      // cleared once the last word has left
      tsr_data_r <= (state_nxt != ST_IDLE);
      // successful transfer in the previous cycle
      tsr_xfer_r <= phase_done;
    end
  end

  // Width flag stays for the whole burst; only a new start clears it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tsr_w64_r  <= 1'b0;
      wide_r     <= 1'b0;
    end else begin
      if (go_data) begin
        tsr_w64_r <= 1'b0;
        wide_r    <= 1'b0;
      end else if (in_data_mode && !devsel_n && !ack64_n) begin
        tsr_w64_r <= 1'b1;
        wide_r    <= 1'b1;
      end
    end
  end

  always_comb begin
    master_transaction_status               = '0;
    master_transaction_status[TSR_DATA_BIT] = tsr_data_r;
    master_transaction_status[TSR_XFER_BIT] = tsr_xfer_r;
    master_transaction_status[TSR_W64_BIT]  = tsr_w64_r;
  end

  // Local output stage; pins come straight from active-low flops
  // acknowledge and strobe drop with the mode flag
  wire to_idle  = (state_nxt == ST_IDLE);
  // acknowledge once a registered word is waiting
  wire ack_nxt  = !to_idle && (!ack_n_r || wf.out_valid);
  // local ready sampled now, strobe shown next cycle
  wire dxfr_nxt = !to_idle && pop_word;
  // dword acknowledges qualify the word with the strobe
  wire hdat_nxt = dxfr_nxt && wide_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_n_r  <= 1'b1;
      dxfr_n_r <= 1'b1;
      ldat_n_r <= 1'b1;
      hdat_n_r <= 1'b1;
      dato_r   <= '0;
    end else begin
      ack_n_r  <= !ack_nxt;
      dxfr_n_r <= !dxfr_nxt;
      ldat_n_r <= !dxfr_nxt;
      hdat_n_r <= !hdat_nxt;
      if (pop_word) dato_r <= wf.out_data;
    end
  end

  assign local_master_acknowledge_n     = ack_n_r;
  assign local_master_transfer_strobe_n = dxfr_n_r;
  assign low_dword_ack_n                = ldat_n_r;
  assign high_dword_ack_n               = hdat_n_r;
  assign local_read_data                = dato_r;

  // Register port
  // One address compare shared by every register select
  function automatic logic reg_hit(
    input logic [REG_AW-1:0] addr,
    input logic [REG_AW-1:0] offset
  );
    reg_hit = (addr == offset);
  endfunction : reg_hit

  wire sel_ctrl   = reg_hit(reg_addr, REG_CTRL);
  wire sel_status = reg_hit(reg_addr, REG_STATUS);
  wire sel_count  = reg_hit(reg_addr, REG_COUNT);

  wire [31:0] rd_mux =
    sel_ctrl   ? {31'h0, enable_r} :
    sel_status ? {{(32-TSR_W){1'b0}}, master_transaction_status} :
    sel_count  ? {{(32-COUNT_W){1'b0}}, count_r} :
                 32'h0;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      enable_r <= CTRL_EN_RST;
    end else if (reg_wr && sel_ctrl) begin
      enable_r <= reg_wdata[CTRL_EN_BIT];
    end
  end

  // Counts words of the current burst; cleared at its start
  always_ff @(posedge clk) begin
    if (sys_rst || go_data) begin
      count_r <= '0;
    end else if (phase_done) begin
      count_r <= COUNT_W'(count_r + 1'b1);
    end
  end

  // Data only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= reg_rd ? rd_mux : 32'h0;
    end
  end

  assign reg_rdata = rdata_r;

endmodule : burst_read_data

`default_nettype wire

// ==== burst_read_sva.sv ====
// Checker for the burst read data-phase block, bound to its top module.
// Assumes one clock and a synchronous active-high reset.
`default_nettype none

module burst_read_sva
  import burst_read_pkg::*;
(
  // Clock, reset, start
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic start_data,
  // Shared bus
  input wire logic irdy_n_o,
  input wire logic irdy_n_oe,
  input wire logic devsel_n,
  input wire logic ack64_n,
  input wire logic trdy_n,
  // Local side
  input wire logic local_master_ready_n,
  input wire logic local_last_transfer_request_n,
  input wire logic local_master_acknowledge_n,
  input wire logic local_master_transfer_strobe_n,
  input wire logic low_dword_ack_n,
  input wire logic high_dword_ack_n,
  input wire logic [burst_read_pkg::TSR_W-1:0] master_transaction_status
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  wire logic [TSR_W-1:0] st   = master_transaction_status;
  wire logic             done = !irdy_n_o && !trdy_n;
  wire logic             lrdy = !local_master_ready_n;
  wire logic             hold = !irdy_n_o && trdy_n;
  logic                  armed_r;
  logic [1:0]            extra_r;

  // Completions after the one that saw the last request
  always_ff @(posedge clk) begin
    if (sys_rst || start_data) begin
      armed_r <= 1'h0;
      extra_r <= 2'h0;
    end else begin
      if (done && !local_last_transfer_request_n) armed_r <= 1'h1;
      if (done && armed_r && extra_r != 2'h3) extra_r <= extra_r + 2'h1;
    end
  end

  a_first_irdy: assert property ($rose(irdy_n_oe) |->
    !irdy_n_o && st[3] && $past(start_data))
    else $error("burst start wrong");
  a_later_irdy: assert property (irdy_n_oe && !$rose(irdy_n_oe)
    && !irdy_n_o |-> $past(lrdy) || $past(hold))
    else $error("irdy without local ready");
  a_wide_status: assert property (irdy_n_oe && !devsel_n
    && !ack64_n |=> st[9] || !st[3])
    else $error("wide status missing");
  a_xfer_status: assert property (st[8] == $past(done))
    else $error("transfer status wrong");
  a_ack_follows: assert property (done && local_master_acknowledge_n
    |-> ##2 !local_master_acknowledge_n)
    else $error("ack late");
  a_strobe_cause: assert property (!local_master_transfer_strobe_n
    |-> !local_master_acknowledge_n && $past(lrdy))
    else $error("strobe without cause");
  a_dword_marks: assert property (
    low_dword_ack_n == local_master_transfer_strobe_n
    && (high_dword_ack_n || !low_dword_ack_n))
    else $error("dword acks wrong");
  a_last_limit: assert property (extra_r <= 2'h1)
    else $error("too many phases after last");
  a_idle_quiet: assert property (!st[3] |-> irdy_n_o
    && local_master_acknowledge_n && local_master_transfer_strobe_n)
    else $error("local side active outside data mode");
endmodule : burst_read_sva

bind burst_read_data burst_read_sva chk_u (.clk, .sys_rst, .start_data,
  .irdy_n_o, .irdy_n_oe, .devsel_n, .ack64_n, .trdy_n, .local_master_ready_n,
  .local_last_transfer_request_n, .local_master_acknowledge_n,
  .local_master_transfer_strobe_n, .low_dword_ack_n, .high_dword_ack_n,
  .master_transaction_status);

`default_nettype wire

// ==== pci_target_model.sv ====
// Behavioural target answering a burst memory read, fast or slow.
// Assumes the initiator drives irdy only while its enable is high.
`default_nettype none

module pci_target_model #(
  parameter logic [63:0] BASE = 64'ha5a5_0000_0000_0000
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // Initiator side
  input  wire logic        irdy_n_o,
  input  wire logic        irdy_n_oe,
  // Test controls
  input  wire logic        slow,
  input  wire logic        narrow,
  // Target answers
  output logic             devsel_n,
  output logic             ack64_n,
  output logic             trdy_n,
  output logic      [63:0] ad_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] word_r;
  logic        tick_r;

  // Idle data lines show the complement so stale words never match
  assign ad_in = trdy_n ? ~word_r : word_r;

  always @(posedge clk) begin
    if (sys_rst || !irdy_n_oe) begin
      devsel_n <= 1'h1;
      ack64_n <= 1'h1;
      trdy_n <= 1'h1;
      tick_r <= 1'h0;
      word_r <= BASE;
    end else begin
      devsel_n <= 1'h0;
      ack64_n <= narrow;
      tick_r <= !tick_r;
      // ready, every other cycle when slow
      trdy_n <= slow && tick_r;
      if (!irdy_n_o && !trdy_n) word_r <= word_r + 64'h1;
    end
  end
endmodule : pci_target_model

`default_nettype wire

// ==== tb.sv ====
// Bench for the burst read data-phase block against a model target.
// Assumes the local side and register port are driven from here.
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import burst_read_pkg::*;

  localparam logic [63:0] BASE = 64'ha5a5_0000_0000_0000;
  logic             clk = 1'h0;
  logic             sys_rst = 1'h1;
  logic [3:0]       reg_addr = 4'h0;
  logic [31:0]      reg_wdata = 32'h0;
  logic             reg_wr = 1'h0;
  logic             reg_rd = 1'h0;
  logic             start_data = 1'h0;
  logic             abort_data = 1'h0;
  logic             slow = 1'h0;
  logic             narrow = 1'h0;
  logic             local_master_ready_n = 1'h1;
  logic             local_last_transfer_request_n = 1'h1;
  logic [31:0]      reg_rdata;
  logic             irdy_n_o, irdy_n_oe, devsel_n, ack64_n, trdy_n;
  logic             local_master_acknowledge_n, local_master_transfer_strobe_n;
  logic             low_dword_ack_n, high_dword_ack_n;
  logic [63:0]      ad_in, local_read_data;
  logic [TSR_W-1:0] master_transaction_status;
  int               failures = 0;
  int               checked = 0;
  int               done_cnt = 0;
  int               rx_idx = 0;

  always #2.5 clk = ~clk;

  burst_read_data dut_u (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .start_data, .abort_data, .irdy_n_o, .irdy_n_oe,
    .devsel_n, .ack64_n, .trdy_n, .ad_in, .local_master_ready_n,
    .local_last_transfer_request_n, .local_master_acknowledge_n,
    .local_master_transfer_strobe_n, .low_dword_ack_n, .high_dword_ack_n,
    .local_read_data, .master_transaction_status);
  pci_target_model #(.BASE(BASE)) tgt_u (.clk, .sys_rst, .irdy_n_o,
    .irdy_n_oe, .slow, .narrow, .devsel_n, .ack64_n, .trdy_n, .ad_in);

  task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic finish_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  task automatic reg_write(logic [3:0] a, logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask : reg_write

  task automatic reg_check(logic [3:0] a, logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    @(posedge clk);
    chk("reg_rdata", {32'h0, e}, {32'h0, reg_rdata});
  endtask : reg_check

  // Words leave in bus order; counts completed phases per burst
  always @(posedge clk) begin
    if (!sys_rst && local_master_transfer_strobe_n === 1'h0) begin
      chk("local_read_data", BASE + rx_idx, local_read_data);
      chk("high_dword_ack_n", {63'h0, narrow}, {63'h0, high_dword_ack_n});
      chk("low_dword_ack_n", 0, {63'h0, low_dword_ack_n});
      rx_idx++;
    end
    if (start_data) done_cnt <= 0;
    else if (!irdy_n_o && !trdy_n) done_cnt <= done_cnt + 1;
  end

  // One burst of n words; hold keeps local ready off for a while
  task automatic burst(int n, logic s, logic w, int hold);
    int k;
    int t;
    @(posedge clk);
    slow <= s;
    narrow <= !w;
    rx_idx = 0;
    local_master_ready_n <= (hold != 0);
    start_data <= 1'h1;
    @(posedge clk);
    start_data <= 1'h0;
    if (hold != 0) begin
      repeat (hold) @(posedge clk);
      chk("phases held", 1, done_cnt);
      chk("strobe", 1, local_master_transfer_strobe_n);
      chk("ack", 0, local_master_acknowledge_n);
      local_master_ready_n <= 1'h0;
    end
    t = 0;
    do begin
      @(posedge clk);
      k = done_cnt + ((!irdy_n_o && !trdy_n) ? 1 : 0);
      if (k >= n - 2) local_last_transfer_request_n <= 1'h0;
      t++;
    end while (k < n - 2 && t < 500);
    chk("last timeout", 0, t >= 500);
    @(posedge clk);
    chk("data mode", 1, master_transaction_status[3]);
    chk("wide", w, master_transaction_status[9]);
    t = 0;
    while (master_transaction_status[3] !== 1'h0 && t < 300) begin
      @(posedge clk);
      t++;
    end
    chk("end timeout", 0, t >= 300);
    // ready released only after the last word left
    local_last_transfer_request_n <= 1'h1;
    local_master_ready_n <= 1'h1;
    @(posedge clk);
    chk("words", done_cnt, rx_idx);
    chk("phases", n, done_cnt);
    chk("status", 64'(w) << TSR_W64_BIT, master_transaction_status);
    reg_check(REG_COUNT, done_cnt);
  endtask : burst

  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'h0;
    reg_check(REG_CTRL, 32'h1);
    reg_check(REG_STATUS, 32'h0);
    reg_check(4'hc, 32'h0);
    reg_write(REG_COUNT, 32'h5);
    reg_check(REG_COUNT, 32'h0);
    burst(3, 1'h0, 1'h1, 0);
    burst(5, 1'h0, 1'h0, 0);
    burst(4, 1'h0, 1'h1, 10);
    burst(6, 1'h1, 1'h1, 0);
    // Abort cuts the bus phases; words already taken still drain
    @(posedge clk);
    rx_idx = 0;
    local_master_ready_n <= 1'h0;
    start_data <= 1'h1;
    @(posedge clk);
    start_data <= 1'h0;
    repeat (3) @(posedge clk);
    abort_data <= 1'h1;
    @(posedge clk);
    abort_data <= 1'h0;
    repeat (8) @(posedge clk);
    chk("abort oe", 0, irdy_n_oe);
    chk("abort phases", 2, done_cnt);
    chk("abort words", done_cnt, rx_idx);
    chk("abort mode", 0, master_transaction_status[3]);
    local_master_ready_n <= 1'h1;
    reg_write(REG_CTRL, 32'h0);
    @(posedge clk);
    start_data <= 1'h1;
    @(posedge clk);
    start_data <= 1'h0;
    repeat (4) @(posedge clk);
    chk("irdy_n_oe", 0, irdy_n_oe);
    reg_write(REG_CTRL, 32'h1);
    burst(3, 1'h0, 1'h1, 0);
    finish_test;
  end

  // Whole run needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    finish_test;
  end
endmodule : tb

`default_nettype wire
